// ==== rtl/ldc_led_dimming_control.v ====
// Notes on behaviour
// RULE1: Halt bit set enters standby, stops timebase, selection and PWM.
// RULE2: Duty slots kept unchanged during standby.
// RULE3: Standby resets sampling and selection logic.
// RULE4: Freeze bit holds current slot selection; the code blocks only the sampled update, so bypass still sets it.
// RULE5: Reset selects duty slot zero.
// RULE6: Standby release selects slot 0 or 7.
// RULE7: Invert bit maps level i to 7-i.
// RULE8: Sampling interval is 2^(17+N) oscillator clocks.
// RULE9: PWM period is 64 steps of 2^(3+N).
// RULE10: Host picks prescale avoiding visible flicker.
// RULE11: Reset pin restores every default.
// RULE12: Reset clears control bits and fields.
// RULE13: Reset loads all duty slots with zero.
// RULE14: Zero duty off; v gives v+1 steps.
// RULE15: Bypass uses manual level as slot index.
// RULE16: First command byte bit layout fixed.
// RULE17: Slot updates at interval end when free.
// RULE18: New duty taken only at period start.
`timescale 1ns/1ps
`include "ldc_defines.vh"

module ldc_led_dimming_control (
  // Clock, reset, enable
  input  wire                   clk_i,
  input  wire                   rst_n_i,
  input  wire                   ce_i,
  // Register port
  input  wire [`LDC_ADDR_W-1:0] addr_i,
  input  wire [7:0]             wdata_i,
  input  wire                   wr_i,
  input  wire                   rd_i,
  output reg  [7:0]             rdata_o,
  // Quantised light level from the sensor converter
  input  wire [2:0]             light_level_i,
  // Outputs
  output reg                    pwm_o,
  output wire                   standby_o,
  output wire [2:0]             sel_slot_o
);

  // Prescaled tick: 1 << (base + N) cycles
  function [`LDC_TICK_W-1:0] ldc_mask;
    input [4:0] base;
    input [1:0] n;
    reg   [4:0] expo;
    reg   [`LDC_TICK_W-1:0] one;
    begin
      expo     = base + {3'h0, n};
      one      = {{(`LDC_TICK_W-1){1'b0}}, 1'b1};
      // Largest exponent is 20: the shift wraps to zero and the mask is all ones
      ldc_mask = (one << expo) - one;
    end
  endfunction

  // Invert mapping of a level onto a slot
  function [2:0] ldc_map;
    input [2:0] lvl;
    input       inv;
    begin
      ldc_map = inv ? (`LDC_SLOT_LAST - lvl) : lvl;
    end
  endfunction

  reg        bypass_q;
  reg  [2:0] manual_level_q;
  reg        halt_q;
  reg        freeze_q;
  reg        invert_q;
  reg  [1:0] div_q;
  reg  [2:0] duty_idx_q;
  reg  [5:0] duty_q [0:7];
  reg  [2:0] sel_q;
  reg        halt_prev_q;
  reg  [`LDC_TICK_W-1:0] tick_q;
  reg  [5:0] step_q;
  reg  [5:0] cur_duty_q;
  reg  [2:0] lvl_s1_q;
  reg  [2:0] lvl_s2_q;
  integer    i;

  // Next-state values of the read port, timebase, selection and PWM
  reg  [7:0]             rdata_d;
  reg  [`LDC_TICK_W-1:0] tick_d;
  reg  [5:0]             step_d;
  reg  [2:0]             sel_d;
  reg  [5:0]             cur_duty_d;
  reg                    pwm_d;

  wire [`LDC_TICK_W-1:0] step_mask   = ldc_mask(`LDC_STEP_EXP, div_q);
  wire [`LDC_TICK_W-1:0] sample_mask = ldc_mask(`LDC_SAMPLE_EXP, div_q);
  // RULE9: step boundary
  wire step_end   = (tick_q & step_mask) == step_mask;
  // RULE8: interval boundary
  wire sample_end = (tick_q & sample_mask) == sample_mask;
  wire period_end = step_end && (step_q == `LDC_STEP_LAST);

  assign standby_o  = halt_q;
  assign sel_slot_o = sel_q;

  // Register writes
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // RULE11: defaults after reset
      // RULE12: control bits cleared
      bypass_q       <= 1'b0;
      manual_level_q <= `LDC_RST_LEVEL;
      halt_q         <= 1'b0;
      freeze_q       <= 1'b0;
      invert_q       <= 1'b0;
      div_q          <= `LDC_RST_DIV;
      duty_idx_q     <= `LDC_SLOT_FIRST;
      // RULE13: duty slots zeroed
      for (i = 0; i < 8; i = i + 1) begin
        duty_q[i] <= `LDC_RST_DUTY;
      end
    end else if (ce_i && wr_i) begin
      case (addr_i)
        `LDC_REG_CTRL: begin
          // RULE16: command byte layout
          bypass_q       <= wdata_i[`LDC_C1_BYPASS];
          manual_level_q <= wdata_i[`LDC_C1_LVL_HI:`LDC_C1_LVL_LO];
          // RULE1: halt bit enters standby
          halt_q         <= wdata_i[`LDC_C1_HALT];
          freeze_q       <= wdata_i[`LDC_C1_FREEZE];
          invert_q       <= wdata_i[`LDC_C1_INVERT];
        end
        `LDC_REG_RATE: begin
          div_q <= wdata_i[`LDC_C2_DIV_HI:`LDC_C2_DIV_LO];
        end
        `LDC_REG_DUTY_IDX: begin
          duty_idx_q <= wdata_i[2:0];
        end
        `LDC_REG_DUTY_DATA: begin
          // Index auto-advances so eight writes fill slots 0..7
          duty_q[duty_idx_q] <= wdata_i[5:0];
          duty_idx_q         <= duty_idx_q + 3'h1;
        end
        default: begin
          duty_idx_q <= duty_idx_q;
        end
      endcase
    end
  end

  // Read mux; zero outside a read so the port idles quiet
  always @* begin
    rdata_d = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `LDC_REG_CTRL: begin
          rdata_d = {1'b0, bypass_q, manual_level_q, halt_q, freeze_q, invert_q};
        end
        `LDC_REG_RATE: begin
          rdata_d = {6'h00, div_q};
        end
        `LDC_REG_DUTY_IDX: begin
          rdata_d = {5'h00, duty_idx_q};
        end
        `LDC_REG_DUTY_DATA: begin
          rdata_d = {2'h0, duty_q[duty_idx_q]};
        end
        `LDC_REG_STATUS: begin
          rdata_d = {4'h0, halt_q, sel_q};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // Read data one cycle after the strobe; held while the enable is low
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= rdata_d;
    end
  end

  // Light level crosses from the analog side
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_s1_q <= 3'h0;
      lvl_s2_q <= 3'h0;
    end else if (ce_i) begin
      lvl_s1_q <= light_level_i;
      lvl_s2_q <= lvl_s1_q;
    end
  end

  // Next timebase; everything parks at zero in standby
  always @* begin
    tick_d = tick_q;
    step_d = step_q;
    if (halt_q) begin
      // RULE1: oscillator stopped
      tick_d = {`LDC_TICK_W{1'b0}};
      step_d = 6'h00;
    end else begin
      tick_d = tick_q + 1'b1;
      // RULE9: step advance
      if (step_end) begin
        // Wraps from the last step back to the first
        step_d = step_q + 6'h01;
      end
    end
  end

  // Next selected slot; release wins over bypass and sampling
  always @* begin
    sel_d = sel_q;
    if (halt_q) begin
      // RULE3: selection back to initial
      // RULE2: duty slots untouched here
      sel_d = `LDC_SLOT_FIRST;
    end else if (halt_prev_q) begin
      // RULE6: release selects first or last
      sel_d = invert_q ? `LDC_SLOT_LAST : `LDC_SLOT_FIRST;
    end else if (bypass_q) begin
      // RULE15: manual level selects slot
      sel_d = manual_level_q;
    end else if (sample_end && !freeze_q) begin
      // RULE17: update at interval end
      // RULE4: freeze skips this update
      // RULE7: inverted mapping
      sel_d = ldc_map(lvl_s2_q, invert_q);
    end
  end

  // Next duty and output; a new slot value waits for the period wrap
  always @* begin
    cur_duty_d = cur_duty_q;
    pwm_d      = 1'b0;
    if (halt_q) begin
      cur_duty_d = `LDC_RST_DUTY;
      pwm_d      = 1'b0;
    end else begin
      // RULE18: new duty at period start
      if (period_end) begin
        cur_duty_d = duty_q[sel_q];
      end
      // RULE14: zero off, else v+1 steps
      pwm_d = (cur_duty_q != `LDC_RST_DUTY) && (step_q <= cur_duty_q);
    end
  end

  // Timebase and slot selection registers
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_q      <= {`LDC_TICK_W{1'b0}};
      step_q      <= 6'h00;
      halt_prev_q <= 1'b0;
      // RULE5: slot zero after reset
      sel_q       <= `LDC_SLOT_FIRST;
    end else if (ce_i) begin
      halt_prev_q <= halt_q;
      tick_q      <= tick_d;
      step_q      <= step_d;
      sel_q       <= sel_d;
    end
  end

  // PWM registers; a flip-flop output cannot glitch the LED switch
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_duty_q <= `LDC_RST_DUTY;
      pwm_o      <= 1'b0;
    end else if (ce_i) begin
      cur_duty_q <= cur_duty_d;
      pwm_o      <= pwm_d;
    end
  end

endmodule

// ==== rtl/ldc_defines.vh ====
`ifndef LDC_DEFINES_VH
`define LDC_DEFINES_VH

// Register indices of the plain register port
`define LDC_ADDR_W        3
`define LDC_REG_CTRL      3'h0
`define LDC_REG_RATE      3'h1
`define LDC_REG_DUTY_IDX  3'h2
`define LDC_REG_DUTY_DATA 3'h3
`define LDC_REG_STATUS    3'h4

// First command byte fields
`define LDC_C1_BYPASS     6
`define LDC_C1_LVL_HI     5
`define LDC_C1_LVL_LO     3
`define LDC_C1_HALT       2
`define LDC_C1_FREEZE     1
`define LDC_C1_INVERT     0

// Second command byte field
`define LDC_C2_DIV_HI     1
`define LDC_C2_DIV_LO     0

// Reset values and slot bounds
`define LDC_RST_DUTY      6'h00
`define LDC_RST_LEVEL     3'h0
`define LDC_RST_DIV       2'h0
`define LDC_SLOT_FIRST    3'h0
`define LDC_SLOT_LAST     3'h7

// Timing exponents: sample interval 2^(17+N), step 2^(3+N)
`define LDC_SAMPLE_EXP    5'h11
`define LDC_STEP_EXP      5'h03
`define LDC_TICK_W        20
`define LDC_STEP_LAST     6'h3F

`endif

// ==== tb/ldc_props.sv ====
`timescale 1ns/1ps
`include "ldc_defines.vh"
module ldc_props (
  // Watched ports
  input wire                   clk_i,
  input wire                   rst_n_i,
  input wire                   ce_i,
  input wire [`LDC_ADDR_W-1:0] addr_i,
  input wire [7:0]             wdata_i,
  input wire                   wr_i,
  input wire                   rd_i,
  input wire [7:0]             rdata_o,
  input wire                   pwm_o,
  input wire                   standby_o,
  input wire [2:0]             sel_slot_o
);
  reg [7:0] cmd_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow of the first command byte, to know when selection is frozen
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) cmd_q <= 8'h00;
    else if (wr_i && ce_i && addr_i == `LDC_REG_CTRL) cmd_q <= wdata_i;
  sequence s_cmd; wr_i && ce_i && addr_i == `LDC_REG_CTRL; endsequence
  sequence s_low_power_halt; standby_o [*3]; endsequence
  property p_halt; s_cmd |=> standby_o == $past(wdata_i[2]); endproperty
  property p_bypass;
    s_cmd ##0 (wdata_i[6] && !wdata_i[2] && !standby_o) |=> ##1 sel_slot_o == $past(wdata_i[5:3], 2);
  endproperty
  property p_release;
    s_cmd ##0 (standby_o && !wdata_i[2] && !wdata_i[6]) |=> ##1 sel_slot_o == {3{$past(wdata_i[0], 2)}};
  endproperty
  property p_reset; $rose(rst_n_i) |-> sel_slot_o == 3'h0 && !standby_o && !pwm_o; endproperty
  property p_dark; s_low_power_halt |-> !pwm_o; endproperty
  property p_idle; !rd_i && ce_i |=> rdata_o == 8'h00; endproperty
  property p_status;
    rd_i && ce_i && addr_i == `LDC_REG_STATUS |=> rdata_o == {4'h0, $past(standby_o), $past(sel_slot_o)};
  endproperty
  property p_freeze;
    cmd_q[1] && !cmd_q[6] && !standby_o && $past(cmd_q[1]) && !$past(standby_o)
      && !$past(standby_o, 2) |-> $stable(sel_slot_o);
  endproperty
  a_halt: assert property (p_halt) else $error("standby does not follow halt bit");
  a_bypass: assert property (p_bypass) else $error("manual level not selected");
  a_release: assert property (p_release) else $error("wrong slot after wake");
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  a_dark: assert property (p_dark) else $error("pwm active in standby");
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  a_status: assert property (p_status) else $error("status read mismatch");
  a_freeze: assert property (p_freeze) else $error("frozen slot changed");
endmodule
bind ldc_led_dimming_control ldc_props chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .pwm_o(pwm_o), .standby_o(standby_o), .sel_slot_o(sel_slot_o));

// ==== tb/ldc_host_model.sv ====
`timescale 1ns/1ps
module ldc_host_model (
  // Bus master side
  input  wire       clk_i,
  output reg  [2:0] addr_o,
  output reg  [7:0] wdata_o,
  output reg        wr_o,
  output reg        rd_o
);
  logic [7:0] exp_q[$];
  initial {addr_o, wdata_o, wr_o, rd_o} = 13'h0000;
  task automatic wr(input [2:0] a, input [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic rd(input [2:0] a, input [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
  endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic       clk_i, rst_n_i, ce_i, pwm_o, standby_o, rd_d, wr_i, rd_i;
  logic [2:0] addr_i, light_level_i, sel_slot_o;
  logic [7:0] wdata_i, rdata_o;
  logic [5:0] duty[8];
  int         fails, n_tests, hi, lv;
  ldc_led_dimming_control dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .light_level_i(light_level_i),
    .pwm_o(pwm_o), .standby_o(standby_o), .sel_slot_o(sel_slot_o));
  ldc_host_model host_u (.clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input [11:0] got, input [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d errors=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Read results are checked against the oldest queued note
  always @(posedge clk_i) begin
    if (rd_d) chk({4'h0, rdata_o}, {4'h0, host_u.exp_q.pop_front()});
    rd_d <= rd_i & ce_i & rst_n_i;
  end
  always @(posedge clk_i) light_level_i <= 3'($urandom);
  // Any window of one period holds exactly the high time
  task automatic pwm_chk(input [2:0] lvl, input [1:0] n);
    host_u.wr(3'h1, {6'h00, n});
    host_u.wr(3'h0, {2'b01, lvl, 3'b000});
    repeat (3 << (9 + n)) @(posedge clk_i);
    hi = 0;
    repeat (1 << (9 + n)) @(posedge clk_i) hi += pwm_o;
    chk(hi[11:0], duty[lvl] == 0 ? 12'h000 : (duty[lvl] + 12'h001) << (3 + n));
  endtask
  initial begin
    void'($urandom(32'h3d335bde));
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    fails = 0;
    n_tests = 0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    host_u.rd(3'h0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      host_u.wr(3'h2, i[7:0]);
      host_u.rd(3'h3, 8'h00);
      duty[i] = 6'($urandom);
    end
    duty[1] = 6'h00;
    duty[6] = 6'h3F;
    host_u.wr(3'h2, 8'h00);
    for (int i = 0; i < 8; i++) host_u.wr(3'h3, {2'b00, duty[i]});
    host_u.rd(3'h7, 8'h00);
    host_u.wr(3'h7, 8'hFF);
    host_u.rd(3'h4, 8'h00);
    for (int i = 1; i < 8; i += 5) pwm_chk(i[2:0], 2'h0);
    lv = $urandom % 8;
    pwm_chk(lv[2:0], 2'h1);
    host_u.wr(3'h0, 8'h04);
    repeat (600) @(posedge clk_i);
    host_u.wr(3'h2, 8'h05);
    host_u.rd(3'h3, {2'b00, duty[5]});
    host_u.wr(3'h0, 8'h01);
    host_u.rd(3'h4, 8'h07);
    host_u.wr(3'h0, 8'h03);
    repeat (40) @(posedge clk_i);
    host_u.rd(3'h4, 8'h07);
    ce_i <= 1'b0;
    host_u.wr(3'h0, 8'h04);
    ce_i <= 1'b1;
    host_u.rd(3'h4, 8'h07);
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    host_u.wr(3'h2, 8'h06);
    host_u.rd(3'h3, 8'h00);
    host_u.rd(3'h4, 8'h00);
    repeat (4) @(posedge clk_i);
    test_done;
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    fails++;
    test_done;
  end
endmodule
